// >>> tec_regs.svh
`ifndef TEC_REGS_SVH
`define TEC_REGS_SVH

// ****************************************
// Field positions and reset values
// ****************************************
`define TEC_CLK_SEL_LSB 0
`define TEC_CLR_MODE_LSB 2
`define TEC_TIMING_LSB 4
`define TEC_MODE_RST 8'h00
`define TEC_OUT_MODE_RST 8'h00
`define TEC_OUT_SELFCLR 8'hDD
`define TEC_OM_FORCE 0
`define TEC_OM_INVERT 1
`define TEC_OM_RESET_LV 2
`define TEC_OM_SET_LV 3
`define TEC_OM_NIBBLE 4
`define TEC_CNT_ZERO 16'h0000
`define TEC_CNT_ONE 16'h0001

// ****************************************
// Timing: divide-by-12 internal count clock
// ****************************************
`define TEC_PHI_DIV_LAST 4'hB
`define TEC_PHI_DIV_ZERO 4'h0

`endif

// >>> tec_pkg.sv
package tec_pkg;
    typedef enum logic [1:0] {
        TEC_CLK_STOP = 2'b00,
        TEC_CLK_PHI_GATED = 2'b01,
        TEC_CLK_PHI = 2'b10,
        TEC_CLK_PIN = 2'b11
    } tec_clk_sel_e;

    typedef enum logic [1:0] {
        TEC_CLR_NONE = 2'b00,
        TEC_CLR_MATCH_B = 2'b01,
        TEC_CLR_EDGE = 2'b10,
        TEC_CLR_MATCH_A = 2'b11
    } tec_clr_mode_e;

    typedef struct packed {
        logic edge_irq;
        logic match_b_irq;
        logic match_a_irq;
    } tec_irq_s;
endpackage

// >>> tec_event_counter.sv
`include "tec_regs.svh"

// Overview of operation
// - 16-bit up-counter steps once per selected pulse; cleared only by reset and clear logic.
// - Capture loads count on pin fall, or timer-output fall when pin is counted.
// - Two independent 16-bit limit registers, written and read as whole words.
// - After each increment, compare with both limits and flag each match.
// - Three interrupt pulses: limit A match, limit B match, capture edge.
// - Mode 09H counts the divided clock while the count pin is high.
// - In that mode a pin fall captures, clears the counter, raises edge interrupt.
// - Each pulse output has a level flop and a separate output latch.
// - Selected match copies level to latch and optionally inverts the level.
// - Clear-on-B mode restarts the counter from zero on limit B match.
// - Mode bits: clock select, clear mode, output A timing, output B timing.
// - Internal count clock is system clock divided by 12.
// - Reset and hardware stop clear the mode register to 00H.
// - Output-mode bits force, invert-enable, and set/reset the level flops.
// - Force and set/reset bits self-clear after acting; invert enables persist.
// - Reset and hardware stop clear the output-mode register to 00H.
// - Both matches as timing with inversion give a two-segment square wave.
// - Timer square output is a selectable reference source for the counter.
module tec_event_counter
    import tec_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic hw_stop,
    // External and timer inputs
    input wire logic count_input_pin,
    input wire logic timer_square_output,
    // Register writes
    input wire logic wr_mode,
    input wire logic wr_out_mode,
    input wire logic [7:0] wr_data8,
    input wire logic wr_limit_a,
    input wire logic wr_limit_b,
    input wire logic [15:0] wr_data16,
    // Register readback
    output logic [15:0] event_up_counter,
    output logic [15:0] capture_hold,
    output logic [15:0] compare_limit_a,
    output logic [15:0] compare_limit_b,
    output logic [7:0] event_counter_mode,
    output logic [7:0] pulse_output_mode,
    // Events and pins
    output tec_pkg::tec_irq_s irq,
    output logic pulse_out_a,
    output logic pulse_out_b
);
    import tec_pkg::*;

    // ****************************************
    // Input synchronisers and divider
    // ****************************************
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic [1:0] next_sync_a;
    logic [1:0] next_sync_b;
    logic ci_q;
    logic to_q;
    logic ci_fall;
    logic to_fall;
    logic [3:0] phi_div;
    logic [3:0] next_phi_div;
    logic phi_tick;

    always_comb begin
        next_sync_a = {sync_a[0], count_input_pin};
        next_sync_b = {sync_b[0], timer_square_output};
        // Edges look only at the second stage and its delayed copy
        ci_fall = ci_q & ~sync_a[1];
        to_fall = to_q & ~sync_b[1];
        phi_tick = (phi_div == `TEC_PHI_DIV_LAST);
        next_phi_div = phi_tick ? `TEC_PHI_DIV_ZERO : phi_div + 4'h1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            ci_q <= 1'b0;
            to_q <= 1'b0;
            phi_div <= `TEC_PHI_DIV_ZERO;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            ci_q <= sync_a[1];
            to_q <= sync_b[1];
            phi_div <= next_phi_div;
        end
    end

    // ****************************************
    // Counter, capture, compare, registers
    // ****************************************
    tec_clk_sel_e clk_sel;
    tec_clr_mode_e clr_mode;
    logic [15:0] cnt_plus;
    logic inc;
    logic cap_edge;
    logic [1:0] match_now;
    logic [15:0] next_cnt;
    logic [15:0] next_cap;
    logic [15:0] next_lim_a;
    logic [15:0] next_lim_b;
    logic [7:0] next_mode;
    logic [7:0] next_out_mode;
    tec_irq_s next_irq;

    always_comb begin
        clk_sel = tec_clk_sel_e'(event_counter_mode[`TEC_CLK_SEL_LSB +: 2]);
        clr_mode = tec_clr_mode_e'(event_counter_mode[`TEC_CLR_MODE_LSB +: 2]);
        cnt_plus = event_up_counter + `TEC_CNT_ONE;
        case (clk_sel)
            TEC_CLK_STOP: inc = 1'b0;
            TEC_CLK_PHI_GATED: inc = phi_tick & sync_a[1];
            TEC_CLK_PHI: inc = phi_tick;
            TEC_CLK_PIN: inc = ci_fall;
            default: inc = 1'b0;
        endcase
        // Pin-counted mode takes the timer output as its time base
        cap_edge = (clk_sel == TEC_CLK_PIN) ? to_fall : ci_fall;
        match_now[0] = inc & (cnt_plus == compare_limit_a);
        match_now[1] = inc & (cnt_plus == compare_limit_b);
        next_cnt = event_up_counter;
        if (clr_mode == TEC_CLR_EDGE && cap_edge) begin
            next_cnt = `TEC_CNT_ZERO;
        end else if (inc) begin
            if ((clr_mode == TEC_CLR_MATCH_B && match_now[1]) ||
                (clr_mode == TEC_CLR_MATCH_A && match_now[0])) begin
                next_cnt = `TEC_CNT_ZERO;
            end else begin
                next_cnt = cnt_plus;
            end
        end
        // Capture sees the count before any clear in the same cycle
        next_cap = cap_edge ? event_up_counter : capture_hold;
        next_lim_a = wr_limit_a ? wr_data16 : compare_limit_a;
        next_lim_b = wr_limit_b ? wr_data16 : compare_limit_b;
        if (hw_stop) begin
            next_mode = `TEC_MODE_RST;
            next_out_mode = `TEC_OUT_MODE_RST;
        end else begin
            next_mode = wr_mode ? wr_data8 : event_counter_mode;
            // Written bits act for one cycle, then the one-shot bits drop
            next_out_mode = wr_out_mode ? wr_data8
                : (pulse_output_mode & ~`TEC_OUT_SELFCLR);
        end
        next_irq.match_a_irq = match_now[0];
        next_irq.match_b_irq = match_now[1];
        next_irq.edge_irq = cap_edge;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            event_up_counter <= `TEC_CNT_ZERO;
            capture_hold <= `TEC_CNT_ZERO;
            compare_limit_a <= `TEC_CNT_ZERO;
            compare_limit_b <= `TEC_CNT_ZERO;
            event_counter_mode <= `TEC_MODE_RST;
            pulse_output_mode <= `TEC_OUT_MODE_RST;
            irq <= '0;
        end else begin
            event_up_counter <= next_cnt;
            capture_hold <= next_cap;
            compare_limit_a <= next_lim_a;
            compare_limit_b <= next_lim_b;
            event_counter_mode <= next_mode;
            pulse_output_mode <= next_out_mode;
            irq <= next_irq;
        end
    end

    // ****************************************
    // Two-stage pulse outputs
    // ****************************************
    logic [1:0] level_flop;
    logic [1:0] out_latch;
    logic [1:0] fire;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_out
            logic [3:0] om;
            logic next_level;
            logic next_latch;
            always_comb begin
                om = pulse_output_mode[`TEC_OM_NIBBLE * ch +: `TEC_OM_NIBBLE];
                fire[ch] = |(event_counter_mode[`TEC_TIMING_LSB + 2 * ch +: 2]
                    & match_now);
                next_level = level_flop[ch];
                next_latch = out_latch[ch];
                if (fire[ch]) begin
                    next_latch = level_flop[ch];
                end else if (om[`TEC_OM_FORCE]) begin
                    next_latch = level_flop[ch];
                end
                if (om[`TEC_OM_SET_LV]) begin
                    next_level = 1'b1;
                end else if (om[`TEC_OM_RESET_LV]) begin
                    next_level = 1'b0;
                end else if (fire[ch] && om[`TEC_OM_INVERT]) begin
                    next_level = ~level_flop[ch];
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    level_flop[ch] <= 1'b0;
                    out_latch[ch] <= 1'b0;
                end else begin
                    level_flop[ch] <= next_level;
                    out_latch[ch] <= next_latch;
                end
            end
        end
    endgenerate

    assign pulse_out_a = out_latch[0];
    assign pulse_out_b = out_latch[1];

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_count_step;
        inc && clr_mode == TEC_CLR_NONE |=> event_up_counter == $past(event_up_counter) + 16'h1;
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong");
    property p_capture;
        cap_edge |=> capture_hold == $past(event_up_counter);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");
    property p_match_irq;
        inc && cnt_plus == compare_limit_a |=> irq.match_a_irq;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match A lost");
    property p_edge_clear;
        clr_mode == TEC_CLR_EDGE && cap_edge |=> event_up_counter == 16'h0 && irq.edge_irq;
    endproperty
    a_edge_clear: assert property (p_edge_clear) else $error("edge clear wrong");
    property p_clear_b;
        clr_mode == TEC_CLR_MATCH_B && match_now[1] && !cap_edge |=> event_up_counter == 16'h0;
    endproperty
    a_clear_b: assert property (p_clear_b) else $error("match B clear lost");
    property p_divider;
        phi_tick |=> !phi_tick [*8];
    endproperty
    a_divider: assert property (p_divider) else $error("divider too fast");
    property p_stop;
        hw_stop |=> event_counter_mode == 8'h00 && pulse_output_mode == 8'h00;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not clear");
    property p_selfclear;
        !wr_out_mode && !hw_stop |=> (pulse_output_mode & 8'hDD) == 8'h00;
    endproperty
    a_selfclear: assert property (p_selfclear) else $error("one-shot bit stuck");
    property p_hold;
        !fire[0] && !pulse_output_mode[0] |=> $stable(pulse_out_a);
    endproperty
    a_hold: assert property (p_hold) else $error("output A moved");
    property p_transfer;
        fire[0] |=> pulse_out_a == $past(level_flop[0]);
    endproperty
    a_transfer: assert property (p_transfer) else $error("transfer wrong");
    property p_match_b_irq;
        inc && cnt_plus == compare_limit_b |=> irq.match_b_irq;
    endproperty
    a_match_b_irq: assert property (p_match_b_irq) else $error("match B lost");
    property p_edge_irq;
        cap_edge |=> irq.edge_irq;
    endproperty
    a_edge_irq: assert property (p_edge_irq) else $error("edge interrupt lost");
    property p_clear_a;
        clr_mode == TEC_CLR_MATCH_A && match_now[0] |=> event_up_counter == `TEC_CNT_ZERO;
    endproperty
    a_clear_a: assert property (p_clear_a) else $error("match A clear lost");
    property p_gated;
        clk_sel == TEC_CLK_PHI_GATED && !sync_a[1] |-> !inc;
    endproperty
    a_gated: assert property (p_gated) else $error("counted with pin low");
    property p_mode_write;
        wr_mode && !hw_stop |=> event_counter_mode == $past(wr_data8);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");
    property p_invert;
        fire[0] && pulse_output_mode[`TEC_OM_INVERT] && !pulse_output_mode[`TEC_OM_SET_LV]
            && !pulse_output_mode[`TEC_OM_RESET_LV] |=> level_flop[0] != $past(level_flop[0]);
    endproperty
    a_invert: assert property (p_invert) else $error("level not inverted");
    property p_force;
        pulse_output_mode[`TEC_OM_FORCE] |=> pulse_out_a == $past(level_flop[0]);
    endproperty
    a_force: assert property (p_force) else $error("force lost");
    property p_hold_b;
        !fire[1] && !pulse_output_mode[`TEC_OM_NIBBLE + `TEC_OM_FORCE] |=> $stable(pulse_out_b);
    endproperty
    a_hold_b: assert property (p_hold_b) else $error("output B moved");
    property p_transfer_b;
        fire[1] |=> pulse_out_b == $past(level_flop[1]);
    endproperty
    a_transfer_b: assert property (p_transfer_b) else $error("transfer B wrong");
endmodule

// >>> tec_pulse_src.sv
// ****************************************
// Far side: count pin source and timer square output
// ****************************************
module tec_pulse_src (
    // Clock
    input wire logic clk,
    // Pins towards the counter
    output logic count_input_pin,
    output logic timer_square_output
);
    timeunit 1ns;
    timeprecision 1ps;
    int div_cnt;

    initial begin
        count_input_pin = 1'b0;
        timer_square_output = 1'b0;
        div_cnt = 0;
    end

    // The interval timer runs free, so its square output never rests
    always @(posedge clk) begin
        div_cnt <= (div_cnt == 23) ? 0 : div_cnt + 1;
        if (div_cnt == 23) begin
            timer_square_output <= ~timer_square_output;
        end
    end

    // One high pulse on the count pin, length in system clocks
    task automatic ci_high(input int cycles);
        @(posedge clk);
        count_input_pin <= 1'b1;
        repeat (cycles) @(posedge clk);
        count_input_pin <= 1'b0;
    endtask
endmodule

// >>> tb.sv
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tec_pkg::*;
    logic clk, rst, hw_stop, ci, tso;
    logic wr_mode, wr_out_mode, wr_limit_a, wr_limit_b;
    logic [7:0] wr_data8, ecm, pom;
    logic [15:0] wr_data16, cnt, cap, lim_a, lim_b, held_cnt;
    tec_irq_s irq;
    logic pulse_out_a, pulse_out_b, held_out;
    int fail_count, checks_done, n;

    tec_pulse_src u_tec_pulse_src (.clk(clk), .count_input_pin(ci),
        .timer_square_output(tso));

    tec_event_counter u_tec_event_counter (.clk(clk), .rst(rst), .hw_stop(hw_stop),
        .count_input_pin(ci), .timer_square_output(tso), .wr_mode(wr_mode),
        .wr_out_mode(wr_out_mode), .wr_data8(wr_data8), .wr_limit_a(wr_limit_a),
        .wr_limit_b(wr_limit_b), .wr_data16(wr_data16), .event_up_counter(cnt),
        .capture_hold(cap), .compare_limit_a(lim_a), .compare_limit_b(lim_b),
        .event_counter_mode(ecm), .pulse_output_mode(pom), .irq(irq),
        .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr8(input logic to_mode, input logic [7:0] d);
        @(posedge clk);
        wr_mode <= to_mode;
        wr_out_mode <= ~to_mode;
        wr_data8 <= d;
        @(posedge clk);
        wr_mode <= 1'b0;
        wr_out_mode <= 1'b0;
    endtask

    task automatic wr16(input logic to_b, input logic [15:0] d);
        @(posedge clk);
        wr_limit_a <= ~to_b;
        wr_limit_b <= to_b;
        wr_data16 <= d;
        @(posedge clk);
        wr_limit_a <= 1'b0;
        wr_limit_b <= 1'b0;
    endtask

    // Bounded wait: what 0 = edge interrupt, 1/2 = output A/B at level v, 3 = match A
    task automatic wait_until(input int what, input logic v, input int lim, output int c);
        c = 0;
        while (!(what == 0 ? irq.edge_irq === 1'b1 : what == 1 ? pulse_out_a === v
                : what == 2 ? pulse_out_b === v : irq.match_a_irq === 1'b1)) begin
            if (c == lim) begin
                fail_count++;
                $display("[FAIL] t=%0t got=%0h exp=%0h", $time, c, lim);
                give_verdict();
            end
            tick(1);
            c++;
        end
    endtask

    task automatic sc_reset_and_limits();
        tick(1);
        `CHK(ecm, 8'h00);
        `CHK(pom, 8'h00);
        wr16(1'b0, 16'h0002);
        wr16(1'b1, 16'h0005);
        tick(1);
        `CHK({lim_a, lim_b}, 32'h0002_0005);
    endtask

    task automatic sc_pulse_width();
        wr8(1'b1, 8'h09);
        tick(1);
        `CHK(ecm, 8'h09);
        // A whole number of 12-cycle periods gives an exact tick count
        u_tec_pulse_src.ci_high(12 * 7);
        wait_until(0, 1'b0, 40, n);
        `CHK(cap, 16'h0007);
        tick(1);
        `CHK(cnt, 16'h0000);
    endtask

    task automatic sc_square_wave();
        wr8(1'b1, 8'h00);
        wr8(1'b0, 8'h0A);
        tick(2);
        `CHK(pom, 8'h02);
        `CHK(pulse_out_a, 1'b0);
        wr8(1'b1, 8'h36);
        wait_until(1, 1'b1, 120, n);
        `CHK(cnt, 16'h0002);
        `CHK(irq.match_a_irq, 1'b1);
        wait_until(1, 1'b0, 120, n);
        `CHK(n, 36);
        wait_until(1, 1'b1, 120, n);
        `CHK(n, 24);
    endtask

    task automatic sc_hw_stop();
        @(posedge clk);
        hw_stop <= 1'b1;
        @(posedge clk);
        hw_stop <= 1'b0;
        tick(1);
        `CHK({ecm, pom}, 16'h0000);
        held_out = pulse_out_a;
        held_cnt = cnt;
        tick(40);
        `CHK(pulse_out_a, held_out);
        `CHK(cnt, held_cnt);
    endtask

    // Pin-counted mode, output B, force and set/reset, clear on match A
    task automatic sc_pin_count();
        wr8(1'b0, 8'h31);
        tick(2);
        `CHK(pulse_out_a, 1'b0);
        `CHK(pom, 8'h20);
        wr8(1'b0, 8'hA0);
        tick(2);
        `CHK(pulse_out_b, 1'b0);
        wr8(1'b1, 8'h83);
        repeat (3) u_tec_pulse_src.ci_high(4);
        wait_until(2, 1'b1, 10, n);
        `CHK(cnt, 16'h0005);
        `CHK(irq.match_b_irq, 1'b1);
        // Forcing now shows whether the match inverted the level
        wr8(1'b0, 8'h30);
        tick(2);
        `CHK(pulse_out_b, 1'b0);
        // The count rests, so any timer fall from here captures it
        wait_until(0, 1'b0, 60, n);
        `CHK(cap, 16'h0005);
        wr8(1'b0, 8'h80);
        wr8(1'b0, 8'h50);
        tick(2);
        `CHK(pulse_out_b, 1'b1);
        wr8(1'b0, 8'h10);
        tick(2);
        `CHK(pulse_out_b, 1'b0);
        wr16(1'b0, 16'h0007);
        wr8(1'b1, 8'h0E);
        wait_until(3, 1'b0, 40, n);
        `CHK(cnt, 16'h0000);
    endtask

    initial begin
        fail_count = 0;
        checks_done = 0;
        rst = 1'b1;
        hw_stop = 1'b0;
        wr_mode = 1'b0;
        wr_out_mode = 1'b0;
        wr_limit_a = 1'b0;
        wr_limit_b = 1'b0;
        wr_data8 = 8'h00;
        wr_data16 = 16'h0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        sc_reset_and_limits();
        sc_pulse_width();
        sc_square_wave();
        sc_hw_stop();
        sc_pin_count();
        give_verdict();
    end
endmodule
